// [pkg/sim_params.svh]
`ifndef SIM_PARAMS_SVH
`define SIM_PARAMS_SVH

`define SIM_MCLK_KHZ 40000
`define SIM_WIN_HAND_MS 500
`define SIM_WIN_DOOR_MS 2500
`define SIM_PAUSE_MS 500
`define SIM_BLANK_MS 1
`define SIM_WIN_HAND_CYC (`SIM_WIN_HAND_MS * `SIM_MCLK_KHZ)
`define SIM_WIN_DOOR_CYC (`SIM_WIN_DOOR_MS * `SIM_MCLK_KHZ)
`define SIM_PAUSE_CYC (`SIM_PAUSE_MS * `SIM_MCLK_KHZ)
`define SIM_BLANK_CYC (`SIM_BLANK_MS * `SIM_MCLK_KHZ)

`define SIM_CNT_W 27
`define SIM_FLT_W 16
`define SIM_CFG_W 3
`define SIM_STATE_W 4
`define SIM_BLINK_W 24
`define SIM_SETTLE_CYC 27'h0000003

`define SIM_CFG_NONE 3'h0
`define SIM_CFG_HAND 3'h1
`define SIM_CFG_DOOR 3'h2
`define SIM_CFG_ANTI 3'h3
`define SIM_CFG_AUTO 3'h4
`define SIM_CFG_PISTOL 3'h5
`define SIM_CFG_SMART 3'h6
`define SIM_CFG_LOCK 3'h7

`endif

// [pkg/sim_pkg.sv]
`include "sim_params.svh"

package sim_pkg;

  typedef logic [`SIM_CFG_W-1:0] sim_cfg_t;

  typedef enum logic [`SIM_STATE_W-1:0] {
    ST_DETECT,
    ST_START,
    ST_WAIT_OPEN,
    ST_ARMED,
    ST_PAIR,
    ST_BLOCKED,
    ST_ENABLED,
    ST_P_OPEN,
    ST_FAIL
  } sim_state_e;

endpackage

// [rtl/sim_blank_filter.sv]
`timescale 1ns/100ps
`include "sim_params.svh"

module sim_blank_filter #(
  parameter logic [`SIM_FLT_W-1:0] BLANK_CYC = `SIM_FLT_W'(`SIM_BLANK_CYC)
) (
  input logic mclk,
  input logic rst,
  input logic clk_en,
  input logic din,
  output logic dout
);

  logic [`SIM_FLT_W-1:0] cnt;

  // High passes at once; low only after outlasting the blanking time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      dout <= 1'b0;
    end else if (clk_en) begin
      if (din) begin
        cnt <= '0; // [RULE23]
        dout <= 1'b1;
      end else if (cnt >= BLANK_CYC) begin
        dout <= 1'b0; // [RULE15]
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule // sim_blank_filter

// [rtl/sim_interlock_monitor.sv]
`timescale 1ns/100ps
`include "sim_params.svh"

// Functional notes
// RULE1 - Configuration taken from safety socket wiring
// RULE2 - No plug means configuration zero
// RULE3 - Configuration zero always forces safe state
// RULE4 - Two-hand: actuated at power-up refuses enabling
// RULE5 - Two-hand channels within 0.5 s
// RULE6 - Door channels within 2.5 s
// RULE7 - After violation, need full release and retry
// RULE8 - Never enable on one channel only
// RULE9 - Door: unequal channels at power-up refused
// RULE10 - Door: wait for open door first
// RULE11 - Door closed at power-up: no enabling
// RULE12 - Automation door: both closed at power-up accepted
// RULE13 - Pistol: open/close by panel, software, host
// RULE14 - Pistol: close only 0.5 s after opening
// RULE15 - Smart inputs filter blanking up to 1 ms
// RULE16 - Smart switch does its own cross-circuit test
// RULE17 - Smart switch drives both channels equal
// RULE18 - Guard lock released by energised output
// RULE19 - Path opening drops enabling; reclose keeps open
// RULE20 - Any fault latches safe state until reinit
// RULE21 - Configuration redetected only on reinit or reset
// RULE22 - Indicator shows enabling, flashes in safe state
// RULE23 - Timing by clock counters, restarted per state
// RULE24 - Configuration and safe flag as status
module sim_interlock_monitor #(
  parameter logic [`SIM_CNT_W-1:0] WIN_HAND_CYC = `SIM_CNT_W'(`SIM_WIN_HAND_CYC),
  parameter logic [`SIM_CNT_W-1:0] WIN_DOOR_CYC = `SIM_CNT_W'(`SIM_WIN_DOOR_CYC),
  parameter logic [`SIM_CNT_W-1:0] PAUSE_CYC = `SIM_CNT_W'(`SIM_PAUSE_CYC),
  parameter logic [`SIM_FLT_W-1:0] BLANK_CYC = `SIM_FLT_W'(`SIM_BLANK_CYC)
) (
  input logic mclk,
  input logic rst,
  input logic clk_en,
  input sim_pkg::sim_cfg_t plug_code,
  input logic monitor_input_a,
  input logic monitor_input_c,
  input logic monitor_input_e,
  input logic smart_switch_input_a,
  input logic smart_switch_input_b,
  input logic panel_toggle,
  input logic sw_close_req,
  input logic sw_open_req,
  input logic host_close_req,
  input logic host_open_req,
  input logic reinit_req,
  input logic fault_in,
  input logic unlock_req,
  output logic enable_closed,
  output logic guard_release_output,
  output logic channel_supply_output_b,
  output logic channel_supply_output_c,
  output logic safety_led,
  output sim_pkg::sim_cfg_t cfg_num,
  output logic fail_safe,
  output logic sim_violation,
  output logic startup_refused,
  output logic [`SIM_STATE_W-1:0] state_code
);

  import sim_pkg::*;

  sim_state_e state;
  sim_cfg_t cfg;
  logic [`SIM_CNT_W-1:0] cnt;
  logic [`SIM_CNT_W-1:0] win;
  logic [8:0] pin_s1;
  logic [8:0] pin_s2;
  logic toggle_d;
  logic toggle_rise;
  logic smart_a_f;
  logic smart_b_f;
  logic ch_a;
  logic ch_b;
  logic both;
  logic none;
  logic close_req;
  logic open_req;
  logic fault_now;
  logic viol;
  logic refused;
  logic [`SIM_BLINK_W-1:0] blink;
  sim_cfg_t plug_s;
  logic mon_a_s;
  logic mon_c_s;
  logic mon_e_s;
  logic toggle_s;

  // Configurations judged as a two-channel pair
  function automatic logic pair_cfg(input sim_cfg_t c);
    pair_cfg = (c != `SIM_CFG_NONE) && (c != `SIM_CFG_PISTOL);
  endfunction

  // Door configurations that insist on an open door at power-up
  function automatic logic open_first(input sim_cfg_t c);
    open_first = (c == `SIM_CFG_DOOR) || (c == `SIM_CFG_ANTI) || (c == `SIM_CFG_LOCK);
  endfunction

  // Two-stage synchronisers for every pin input
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (clk_en) begin
      pin_s1 <= {plug_code, monitor_input_a, monitor_input_c, monitor_input_e,
                 smart_switch_input_a, smart_switch_input_b, panel_toggle};
      pin_s2 <= pin_s1;
    end
  end

  assign plug_s = pin_s2[8:6];
  assign mon_a_s = pin_s2[5];
  assign mon_c_s = pin_s2[4];
  assign mon_e_s = pin_s2[3];
  assign toggle_s = pin_s2[0];

  sim_blank_filter #(
    .BLANK_CYC(BLANK_CYC)
  ) u_filt_a (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .din(pin_s2[2]),
    .dout(smart_a_f)
  );

  sim_blank_filter #(
    .BLANK_CYC(BLANK_CYC)
  ) u_filt_b (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .din(pin_s2[1]),
    .dout(smart_b_f)
  );

  // Panel button edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      toggle_d <= 1'b0;
    end else if (clk_en) begin
      toggle_d <= toggle_s;
    end
  end

  assign toggle_rise = toggle_s & ~toggle_d;

  // Channel meaning per wiring; 1 is actuated or door closed
  always_comb begin
    ch_a = 1'b0;
    ch_b = 1'b0;
    case (cfg)
      `SIM_CFG_HAND, `SIM_CFG_DOOR, `SIM_CFG_AUTO: begin
        ch_a = mon_a_s;
        ch_b = mon_c_s;
      end
      `SIM_CFG_ANTI: begin
        ch_a = mon_a_s;
        ch_b = ~mon_c_s;
      end
      `SIM_CFG_SMART: begin
        ch_a = smart_a_f; // [RULE15]
        ch_b = smart_b_f; // [RULE17]
      end
      `SIM_CFG_LOCK: begin
        ch_a = mon_a_s;
        ch_b = mon_e_s;
      end
      default: begin
        ch_a = 1'b0;
        ch_b = 1'b0;
      end
    endcase
  end

  assign both = ch_a & ch_b;
  assign none = ~ch_a & ~ch_b;
  assign win = (cfg == `SIM_CFG_HAND) ? WIN_HAND_CYC : WIN_DOOR_CYC; // [RULE5] [RULE6]

  assign close_req = sw_close_req | host_close_req | (toggle_rise & (state == ST_P_OPEN)); // [RULE13]
  assign open_req = sw_open_req | host_open_req | (toggle_rise & (state == ST_ENABLED)); // [RULE13]

  // Plug pulled or changed counts as a fault, never as a new configuration
  assign fault_now = (state != ST_FAIL) &&
                     (fault_in || ((state != ST_DETECT) && (plug_s != cfg))); // [RULE20] [RULE21]

  // Main sequence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_DETECT;
      cnt <= '0;
      cfg <= `SIM_CFG_NONE;
    end else if (clk_en) begin
      if (reinit_req) begin
        state <= ST_DETECT; // [RULE21]
        cnt <= '0;
      end else if (fault_now) begin
        state <= ST_FAIL; // [RULE20]
      end else begin
        case (state)
          ST_DETECT: begin
            // Wait out the synchronisers before trusting the plug code
            if (cnt >= `SIM_SETTLE_CYC) begin
              cfg <= plug_s; // [RULE1] [RULE2]
              cnt <= '0;
              state <= ST_START;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          ST_START: begin
            if (cfg == `SIM_CFG_NONE) begin
              state <= ST_FAIL; // [RULE3]
            end else if (cfg == `SIM_CFG_PISTOL) begin
              cnt <= PAUSE_CYC;
              state <= ST_P_OPEN;
            end else if ((cfg == `SIM_CFG_AUTO) && both) begin
              state <= ST_ENABLED; // [RULE12]
            end else if (none) begin
              state <= ST_ARMED;
            end else begin
              state <= ST_WAIT_OPEN; // [RULE4] [RULE9] [RULE10] [RULE11]
            end
          end
          ST_WAIT_OPEN: begin
            if (none) begin
              state <= ST_ARMED;
            end
          end
          ST_ARMED: begin
            cnt <= '0; // [RULE23]
            if (both) begin
              state <= ST_ENABLED;
            end else if (!none) begin
              state <= ST_PAIR;
            end
          end
          ST_PAIR: begin
            if (both) begin
              state <= ST_ENABLED;
            end else if (none) begin
              state <= ST_ARMED;
            end else if (cnt >= win) begin
              state <= ST_BLOCKED; // [RULE5] [RULE6] [RULE8]
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          ST_BLOCKED: begin
            if (none) begin
              state <= ST_ARMED; // [RULE7]
            end
          end
          ST_ENABLED: begin
            if (cfg == `SIM_CFG_PISTOL) begin
              if (open_req) begin
                cnt <= '0; // [RULE23]
                state <= ST_P_OPEN;
              end
            end else if (!both) begin
              state <= ST_WAIT_OPEN; // [RULE19]
            end
          end
          ST_P_OPEN: begin
            // Early close requests are dropped, not queued
            if (close_req && (cnt >= PAUSE_CYC)) begin
              state <= ST_ENABLED; // [RULE14]
            end else if (cnt < PAUSE_CYC) begin
              cnt <= cnt + 1'b1;
            end
          end
          ST_FAIL: begin
            state <= ST_FAIL; // [RULE3] [RULE20]
          end
          default: begin
            state <= ST_FAIL;
          end
        endcase
      end
    end
  end

  // Sticky violation, held until a good sequence enables or a reinit request clears it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      viol <= 1'b0;
    end else if (clk_en) begin
      if (reinit_req || (state == ST_ENABLED)) begin
        viol <= 1'b0;
      end else if ((state == ST_PAIR) && !both && !none && (cnt >= win)) begin
        viol <= 1'b1; // [RULE7]
      end
    end
  end

  // Power-up refusal flag, cleared once channels are released
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      refused <= 1'b0;
    end else if (clk_en) begin
      if ((state == ST_START) && pair_cfg(cfg) && !none &&
          !((cfg == `SIM_CFG_AUTO) && both)) begin
        refused <= open_first(cfg) | (cfg != `SIM_CFG_AUTO) | !both; // [RULE4] [RULE9] [RULE11]
      end else if ((state == ST_ARMED) || (state == ST_DETECT)) begin
        refused <= 1'b0;
      end
    end
  end

  // Free-running flash divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      blink <= '0;
    end else if (clk_en) begin
      blink <= blink + 1'b1;
    end
  end

  // Registered outputs; enabling lags the state by one cycle, except that a fault or reinit drops it at once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_closed <= 1'b0;
      fail_safe <= 1'b0;
      safety_led <= 1'b0;
      cfg_num <= `SIM_CFG_NONE;
      state_code <= '0;
      sim_violation <= 1'b0;
      startup_refused <= 1'b0;
    end else if (clk_en) begin
      enable_closed <= (state == ST_ENABLED) && !fault_now && !reinit_req; // [RULE8] [RULE19]
      fail_safe <= (state == ST_FAIL); // [RULE24]
      safety_led <= (state == ST_FAIL) ? blink[`SIM_BLINK_W-1] : (state == ST_ENABLED); // [RULE22]
      cfg_num <= cfg; // [RULE24]
      state_code <= state;
      sim_violation <= viol;
      startup_refused <= refused;
    end
  end

  // Lock held while enabled; supplies live only with a plug detected
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      guard_release_output <= 1'b0;
      channel_supply_output_b <= 1'b0;
      channel_supply_output_c <= 1'b0;
    end else if (clk_en) begin
      guard_release_output <= (cfg == `SIM_CFG_LOCK) && unlock_req &&
                              (state != ST_ENABLED) && (state != ST_DETECT); // [RULE18]
      channel_supply_output_b <= (cfg != `SIM_CFG_NONE) && (state != ST_DETECT);
      channel_supply_output_c <= (cfg != `SIM_CFG_NONE) && (state != ST_DETECT);
    end
  end

endmodule // sim_interlock_monitor

// [dv/sim_switch_model.sv]
`timescale 1ns/100ps

module sim_switch_model (
  input logic act_a,
  input logic act_b,
  input logic anti,
  input logic blank,
  output logic monitor_input_a,
  output logic monitor_input_c,
  output logic monitor_input_e,
  output logic smart_switch_input_a,
  output logic smart_switch_input_b
);
  assign monitor_input_a = act_a;
  // Antivalent pair: second contact reads low when closed
  assign monitor_input_c = anti ? ~act_b : act_b;
  assign monitor_input_e = act_b;
  // Blanking hits both outputs alike, so no cross fault is shown
  assign smart_switch_input_a = act_a & ~blank;
  assign smart_switch_input_b = act_b & ~blank;
endmodule // sim_switch_model

// [dv/sim_monitor_checker.sv]
`timescale 1ns/100ps
`include "sim_params.svh"

module sim_monitor_checker #(
  parameter logic [`SIM_CNT_W-1:0] PAUSE_CYC = `SIM_CNT_W'(`SIM_PAUSE_CYC)
) (
  input logic mclk,
  input logic rst,
  input logic fault_in,
  input logic reinit_req,
  input logic unlock_req,
  input logic monitor_input_a,
  input logic monitor_input_c,
  input logic enable_closed,
  input logic guard_release_output,
  input sim_pkg::sim_cfg_t cfg_num,
  input logic fail_safe,
  input logic [`SIM_STATE_W-1:0] state_code
);
  import sim_pkg::*;
  logic [7:0] open_cnt;
  logic seen_open;

  // Cycles since the circuit last opened; saturates
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      open_cnt <= 8'h00;
      seen_open <= 1'b0;
    end else begin
      if (enable_closed) open_cnt <= 8'h00;
      else if (open_cnt != 8'hff) open_cnt <= open_cnt + 8'h01;
      if (fail_safe) seen_open <= 1'b0;
      else if ($fell(enable_closed)) seen_open <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  fault_drop_a: assert property (fault_in && !reinit_req |=> !enable_closed ##[0:1] fail_safe)
    else $error("fault did not force safe state");
  safe_hold_a: assert property (fail_safe && !reinit_req && !$past(reinit_req) |=> fail_safe)
    else $error("safe state left without reinit");
  cfg_none_a: assert property (cfg_num == 3'h0 |-> !enable_closed && !guard_release_output)
    else $error("enabled without a plug");
  both_chan_a: assert property ($rose(enable_closed) && cfg_num inside {3'h1, 3'h2, 3'h4}
    |-> $past(monitor_input_a, 4) && $past(monitor_input_c, 4))
    else $error("enabled on one channel");
  reclose_a: assert property ($fell(enable_closed) && cfg_num != 3'h5
    ##2 (monitor_input_a && monitor_input_c) [*6] |-> !enable_closed)
    else $error("reclosed path enabled again");
  pause_a: assert property ($rose(enable_closed) && cfg_num == 3'h5 && seen_open
    |-> {19'h0, open_cnt} >= PAUSE_CYC)
    else $error("closed before pause ended");
  guard_on_a: assert property (unlock_req ##1 cfg_num == 3'h7 && state_code != 4'h6 && state_code != 4'h0
    |-> guard_release_output)
    else $error("lock not released");
  guard_off_a: assert property (guard_release_output |-> cfg_num == 3'h7 && !enable_closed)
    else $error("lock released while enabled");

  cover property ($rose(enable_closed));
  cover property ($rose(fail_safe));
  cover property ($rose(guard_release_output));
endmodule // sim_monitor_checker

// [dv/testbench.sv]
`timescale 1ns/100ps
`include "sim_params.svh"

module testbench;
  import sim_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  sim_cfg_t plug_code = 3'h0;
  logic act_a = 1'b0, act_b = 1'b0, anti = 1'b0, blank = 1'b0;
  logic panel_toggle = 1'b0, sw_close_req = 1'b0, sw_open_req = 1'b0;
  logic host_close_req = 1'b0, host_open_req = 1'b0;
  logic reinit_req = 1'b0, fault_in = 1'b0, unlock_req = 1'b0;
  logic monitor_input_a, monitor_input_c, monitor_input_e, smart_switch_input_a, smart_switch_input_b;
  logic enable_closed, guard_release_output, channel_supply_output_b, safety_led, fail_safe, sim_violation;
  logic startup_refused, channel_supply_output_c;
  logic [`SIM_STATE_W-1:0] state_code;
  sim_cfg_t cfg_num;
  int errors = 0, num_checks = 0;

  always #12.5 mclk = ~mclk;

  sim_switch_model u_sim_switch_model (.act_a, .act_b, .anti, .blank, .monitor_input_a, .monitor_input_c,
    .monitor_input_e, .smart_switch_input_a, .smart_switch_input_b);

  // Short counts keep the run brief
  sim_interlock_monitor #(.WIN_HAND_CYC(27'h14), .WIN_DOOR_CYC(27'h32), .PAUSE_CYC(27'h10), .BLANK_CYC(16'h8))
  u_sim_interlock_monitor (.mclk, .rst, .clk_en, .plug_code, .monitor_input_a, .monitor_input_c,
    .monitor_input_e, .smart_switch_input_a, .smart_switch_input_b, .panel_toggle, .sw_close_req,
    .sw_open_req, .host_close_req, .host_open_req, .reinit_req, .fault_in, .unlock_req, .enable_closed,
    .guard_release_output, .channel_supply_output_b, .channel_supply_output_c, .safety_led, .cfg_num,
    .fail_safe, .sim_violation, .startup_refused, .state_code);

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task boot(input sim_cfg_t c, input logic a, input logic b);
    plug_code = c;
    act_a = a;
    act_b = b;
    anti = (c == `SIM_CFG_ANTI);
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    cyc(14);
  endtask

  task rel;
    act_a = 1'b0;
    act_b = 1'b0;
    cyc(8);
  endtask

  task lag(input int n);
    act_a = 1'b1;
    cyc(n);
    act_b = 1'b1;
    cyc(8);
  endtask

  task pulse_reinit;
    reinit_req = 1'b1;
    cyc(1);
    reinit_req = 1'b0;
    cyc(14);
  endtask

  task req(input int s, input logic cl);
    case (s)
      0: if (cl) host_close_req = 1'b1; else host_open_req = 1'b1;
      1: if (cl) sw_close_req = 1'b1; else sw_open_req = 1'b1;
      default: panel_toggle = 1'b1;
    endcase
    cyc(1);
    {host_close_req, host_open_req, sw_close_req, sw_open_req, panel_toggle} = 5'h00;
    cyc(4);
  endtask

  initial begin
    cyc(20000);
    errors++;
    end_of_test;
  end

  initial begin
    boot(`SIM_CFG_NONE, 1'b1, 1'b1);
    chk(enable_closed, 1'b0);
    chk(fail_safe, 1'b1);
    chk(cfg_num, 3'h0);
    chk(state_code, ST_FAIL);
    boot(`SIM_CFG_HAND, 1'b0, 1'b0);
    chk(cfg_num, 3'h1);
    chk(channel_supply_output_b, 1'b1);
    chk(channel_supply_output_c, 1'b1);
    act_a = 1'b1;
    cyc(12);
    chk(enable_closed, 1'b0);
    act_b = 1'b1;
    cyc(8);
    chk(enable_closed, 1'b1);
    chk(safety_led, 1'b1);
    clk_en = 1'b0;
    act_b = 1'b0;
    cyc(8);
    chk(enable_closed, 1'b1);
    clk_en = 1'b1;
    cyc(5);
    chk(enable_closed, 1'b0);
    chk(safety_led, 1'b0);
    act_b = 1'b1;
    cyc(10);
    chk(enable_closed, 1'b0);
    rel;
    lag(30);
    chk(sim_violation, 1'b1);
    chk(enable_closed, 1'b0);
    rel;
    lag(2);
    chk(enable_closed, 1'b1);
    chk(sim_violation, 1'b0);
    boot(`SIM_CFG_HAND, 1'b1, 1'b0);
    act_b = 1'b1;
    cyc(8);
    chk(startup_refused, 1'b1);
    chk(enable_closed, 1'b0);
    boot(`SIM_CFG_ANTI, 1'b1, 1'b0);
    chk(enable_closed, 1'b0);
    boot(`SIM_CFG_AUTO, 1'b1, 1'b1);
    chk(enable_closed, 1'b1);
    boot(`SIM_CFG_DOOR, 1'b1, 1'b1);
    chk(enable_closed, 1'b0);
    rel;
    lag(2);
    chk(enable_closed, 1'b1);
    for (int c = 2; c < 4; c++) begin
      boot(sim_cfg_t'(c), 1'b0, 1'b0);
      lag(30);
      chk(enable_closed, 1'b1);
      rel;
      lag(60);
      chk(sim_violation, 1'b1);
    end
    boot(`SIM_CFG_SMART, 1'b0, 1'b0);
    lag(2);
    chk(enable_closed, 1'b1);
    blank = 1'b1;
    cyc(6);
    blank = 1'b0;
    cyc(6);
    chk(enable_closed, 1'b1);
    blank = 1'b1;
    cyc(14);
    chk(enable_closed, 1'b0);
    blank = 1'b0;
    boot(`SIM_CFG_LOCK, 1'b0, 1'b0);
    unlock_req = 1'b1;
    cyc(3);
    chk(guard_release_output, 1'b1);
    unlock_req = 1'b0;
    lag(2);
    unlock_req = 1'b1;
    cyc(3);
    chk(guard_release_output, 1'b0);
    unlock_req = 1'b0;
    boot(`SIM_CFG_PISTOL, 1'b0, 1'b0);
    req(0, 1'b1);
    chk(enable_closed, 1'b1);
    for (int s = 0; s < 3; s++) begin
      req(s, 1'b0);
      chk(enable_closed, 1'b0);
      req(s, 1'b1);
      chk(enable_closed, 1'b0);
      cyc(16);
      req(s, 1'b1);
      chk(enable_closed, 1'b1);
    end
    fault_in = 1'b1;
    cyc(1);
    fault_in = 1'b0;
    cyc(3);
    chk(fail_safe, 1'b1);
    req(0, 1'b1);
    chk(enable_closed, 1'b0);
    pulse_reinit;
    chk(fail_safe, 1'b0);
    plug_code = `SIM_CFG_DOOR;
    cyc(8);
    chk(cfg_num, 3'h5);
    pulse_reinit;
    chk(cfg_num, 3'h2);
    end_of_test;
  end
endmodule // testbench

bind sim_interlock_monitor sim_monitor_checker #(.PAUSE_CYC(PAUSE_CYC)) u_sim_monitor_checker (.mclk, .rst,
  .fault_in, .reinit_req, .unlock_req, .monitor_input_a, .monitor_input_c, .enable_closed,
  .guard_release_output, .cfg_num, .fail_safe, .state_code);
